// [tsr_serial_regs.sv]
/*
 * register side of a serial temperature sensor: sends the reading word or
 * the identity word, takes the mode command, and holds the mode.
 * assumes temp_code comes from logic on clk_sys and the link clock idles low.
 */
`timescale 1ns/1ns
//
// Contract
// - a command byte of all ones puts the device into shutdown.
// - a command byte of all zeros puts the device into continuous conversion.
// - reading bits 15 to 5 carry the 11-bit two's complement temperature.
// - reading bits 4 to 2 are sent as ones.
// - bits 1 and 0 of either word leave the data pin released.
// - identity bits 4 to 2 are sent as zeros.
// - in shutdown a read returns the identity code in bits 15 to 5.
// - output changes on falling clock edges, input sampled on rising edges.
// - a transaction is 16 clocks out then 16 clocks in.
// - only the last eight bits before chip select rises are acted on.
// - reset starts the device in continuous conversion.
module tsr_serial_regs
   import tsr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic serial_shift_clock,
   input wire logic cs_n,
   input wire logic sio_in,
   output logic sio_out,
   output logic sio_oe,
   input wire logic [tsr_pkg::TEMP_W-1:0] temp_code,
   output logic shutdown
);
   logic fall_toggle;
   logic cmd_seen;
   logic [CMD_W-1:0] cmd_byte;
   logic cs_s1;
   logic cs_s2;
   logic cs_d;
   logic ft_s1;
   logic ft_s2;
   logic ft_d;
   logic frame_end;
   logic fall_ev;
   logic [WORD_W-1:0] tx_word;
   logic [WORD_W-1:0] next_tx_word;
   logic [IDX_W-1:0] bit_idx;
   logic [IDX_W-1:0] next_bit_idx;
   logic next_sio_out;
   logic next_sio_oe;
   logic next_shutdown;
   logic [3:0] idx_bit;

   ////////////////////////////////////////////////////////////////////////////
   // link domain
   tsr_link_rx u_link (
      .serial_shift_clock(serial_shift_clock),
      .cs_n(cs_n),
      .rstn(rstn),
      .sio_in(sio_in),
      .fall_toggle(fall_toggle),
      .cmd_seen(cmd_seen),
      .cmd_byte(cmd_byte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // crossings: chip select level and falling-edge toggle
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d <= 1'b1;
         ft_s1 <= 1'b0;
         ft_s2 <= 1'b0;
         ft_d <= 1'b0;
      end else begin
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
         cs_d <= cs_s2;
         ft_s1 <= fall_toggle;
         ft_s2 <= ft_s1;
         ft_d <= ft_s2;
      end
   end

   assign frame_end = cs_s2 & ~cs_d;
   assign fall_ev = ft_s2 ^ ft_d;
   assign idx_bit = 4'hf - bit_idx[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // mode register; command bytes are stable once chip select is high
   always_comb begin
      next_shutdown = shutdown;
      if (frame_end && cmd_seen) begin
         if (cmd_byte == CMD_SHUTDOWN) begin
            next_shutdown = 1'b1;
         end else begin
            next_shutdown = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         shutdown <= RESET_SHUTDOWN;
      end else begin
         shutdown <= next_shutdown;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit word and pin drive
   always_comb begin
      next_tx_word = tx_word;
      next_bit_idx = bit_idx;
      next_sio_out = 1'b0;
      next_sio_oe = 1'b0;
      if (cs_s2) begin
         next_bit_idx = IDX_FIRST;
         if (shutdown) begin
            next_tx_word = {ID_CODE, ID_FILL, UNDEF_BITS};
         end else begin
            next_tx_word = {temp_code, TEMP_FILL, UNDEF_BITS};
         end
      end else begin
         if (fall_ev && bit_idx != IDX_LAST) begin
            next_bit_idx = bit_idx + 5'h01;
         end
         if (next_bit_idx < IDX_RELEASE) begin
            next_sio_oe = 1'b1;
            next_sio_out = tx_word[4'hf - next_bit_idx[3:0]];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tx_word <= {WORD_W{1'b0}};
         bit_idx <= IDX_FIRST;
         sio_out <= 1'b0;
         sio_oe <= 1'b0;
      end else begin
         tx_word <= next_tx_word;
         bit_idx <= next_bit_idx;
         sio_out <= next_sio_out;
         sio_oe <= next_sio_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_frame_end_cmd(logic [CMD_W-1:0] code);
      frame_end && cmd_seen && cmd_byte == code;
   endsequence

   sequence s_bit_shown;
      sio_oe && !cs_s2;
   endsequence

   a_shutdown_on_ones: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      s_frame_end_cmd(CMD_SHUTDOWN) |=> shutdown [*2])
      else $error("shutdown command not taken");

   a_convert_on_zeros: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      s_frame_end_cmd(CMD_CONVERT) |=> !shutdown)
      else $error("conversion command not taken");

   a_temp_bits_out: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      s_bit_shown and (!$past(shutdown, 2) && bit_idx < IDX_FILL_FIRST && $stable(tx_word))
      |-> sio_out == tx_word[idx_bit])
      else $error("temperature bit wrong");

   a_temp_word_load: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      cs_s2 && !shutdown |=> tx_word == {$past(temp_code), TEMP_FILL, UNDEF_BITS})
      else $error("reading word not loaded from temperature");

   a_temp_fill_ones: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      s_bit_shown and (tx_word[WORD_W-1:FILL_W+2] == $past(temp_code, 3) && $stable(tx_word)
      && bit_idx >= IDX_FILL_FIRST && tx_word[FILL_W+1:2] == TEMP_FILL) |-> sio_out)
      else $error("reading fill bit not one");

   a_release_low_bits: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      bit_idx >= IDX_RELEASE |-> !sio_oe)
      else $error("data pin driven during low bits");

   a_id_fill_zeros: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      s_bit_shown and (bit_idx >= IDX_FILL_FIRST && tx_word[FILL_W+1:2] == ID_FILL
      && tx_word[WORD_W-1:FILL_W+2] == ID_CODE) |-> !sio_out)
      else $error("identity fill bit not zero");

   a_oe_idle: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      cs_s2 |=> !sio_oe)
      else $error("data pin driven outside a frame");

   a_first_bit_drive: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      $fell(cs_s2) |=> sio_oe)
      else $error("first bit not driven after chip select fell");

   a_id_in_shutdown: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      cs_s2 && shutdown |=> tx_word == {ID_CODE, ID_FILL, UNDEF_BITS})
      else $error("identity word not loaded in shutdown");

   a_bit_advance: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !cs_s2 && fall_ev && bit_idx < 5'h0f |=> bit_idx == $past(bit_idx) + 5'h01)
      else $error("bit index did not advance on falling edge");

   a_short_write_kept: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      frame_end && !cmd_seen |=> $stable(shutdown))
      else $error("mode changed without a full command byte");

   a_reset_mode: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      $rose(rstn) |-> !shutdown ##1 !shutdown)
      else $error("device not in conversion after reset");
endmodule

// [tsr_pkg.sv]
/*
 * constants shared by the serial temperature register block:
 * word layout, command codes, bit counts and reset values.
 * assumes a host that acts as serial master with the clock idling low.
 */
package tsr_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // word layout
   localparam int WORD_W = 16;
   localparam int TEMP_W = 11;
   localparam int FILL_W = 3;
   localparam int IDX_W = 5;
   localparam int EDGE_W = 6;
   localparam int CMD_W = 8;
   localparam logic [FILL_W-1:0] TEMP_FILL = 3'h7;
   localparam logic [FILL_W-1:0] ID_FILL = 3'h0;
   localparam logic [1:0] UNDEF_BITS = 2'h0;
   // identity bits 15..5; value is arbitrary
   localparam logic [TEMP_W-1:0] ID_CODE = 11'h2c5;
   ////////////////////////////////////////////////////////////////////////////
   // bit positions in the outgoing word, counted from the first bit sent
   localparam logic [IDX_W-1:0] IDX_FIRST = 5'h00;
   localparam logic [IDX_W-1:0] IDX_FILL_FIRST = 5'h0b;
   localparam logic [IDX_W-1:0] IDX_RELEASE = 5'h0e;
   localparam logic [IDX_W-1:0] IDX_LAST = 5'h10;
   ////////////////////////////////////////////////////////////////////////////
   // link edge counts and command codes
   localparam logic [EDGE_W-1:0] EDGE_ZERO = 6'h00;
   localparam logic [EDGE_W-1:0] EDGE_ONE = 6'h01;
   localparam logic [EDGE_W-1:0] EDGE_CMD_MIN = 6'h17;
   localparam logic [EDGE_W-1:0] EDGE_MAX = 6'h20;
   localparam logic [CMD_W-1:0] CMD_SHUTDOWN = 8'hff;
   localparam logic [CMD_W-1:0] CMD_CONVERT = 8'h00;
   localparam logic RESET_SHUTDOWN = 1'b0;
endpackage

// [tsr_link_rx.sv]
/*
 * link-side logic on the serial shift clock: samples the data pin on
 * rising edges, keeps the last command byte, and toggles on falling edges.
 * assumes chip select high holds the clock still and rstn held long enough.
 */
`timescale 1ns/1ns
module tsr_link_rx
   import tsr_pkg::*;
(
   input wire logic serial_shift_clock,
   input wire logic cs_n,
   input wire logic rstn,
   input wire logic sio_in,
   output logic fall_toggle,
   output logic cmd_seen,
   output logic [tsr_pkg::CMD_W-1:0] cmd_byte
);
   logic [EDGE_W-1:0] edge_cnt;
   logic [EDGE_W-1:0] next_edge_cnt;
   logic [CMD_W-1:0] rx_shift;
   logic [CMD_W-1:0] next_rx_shift;
   logic next_cmd_seen;
   logic [CMD_W-1:0] next_cmd_byte;
   logic next_fall_toggle;

   ////////////////////////////////////////////////////////////////////////////
   // receive side: rising edges
   always_comb begin
      next_edge_cnt = (edge_cnt == EDGE_MAX) ? edge_cnt : edge_cnt + EDGE_ONE;
      next_rx_shift = {rx_shift[CMD_W-2:0], sio_in};
      next_cmd_seen = cmd_seen;
      next_cmd_byte = cmd_byte;
      if (edge_cnt >= EDGE_CMD_MIN) begin
         next_cmd_seen = 1'b1;
         next_cmd_byte = next_rx_shift;
      end else if (edge_cnt == EDGE_ZERO) begin
         next_cmd_seen = 1'b0;
      end
      next_fall_toggle = ~fall_toggle;
   end

   always_ff @(posedge serial_shift_clock or posedge cs_n or negedge rstn) begin
      if (cs_n || !rstn) begin
         edge_cnt <= EDGE_ZERO;
      end else begin
         edge_cnt <= next_edge_cnt;
      end
   end

   always_ff @(posedge serial_shift_clock or negedge rstn) begin
      if (!rstn) begin
         rx_shift <= CMD_CONVERT;
         cmd_seen <= 1'b0;
         cmd_byte <= CMD_CONVERT;
      end else begin
         rx_shift <= next_rx_shift;
         cmd_seen <= next_cmd_seen;
         cmd_byte <= next_cmd_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit pacing: falling edges
   always_ff @(negedge serial_shift_clock or negedge rstn) begin
      if (!rstn) begin
         fall_toggle <= 1'b0;
      end else begin
         fall_toggle <= next_fall_toggle;
      end
   end
endmodule

// [tsr_host_model.sv]
/*
 * host master model for the serial temperature register block:
 * runs frames of 16 read clocks and 0..16 write clocks at 48 ns.
 * assumes the device releases the data pin with sio_oe low.
 */
`timescale 1ns/1ns
module tsr_host_model (
   output logic serial_shift_clock,
   output logic cs_n,
   output logic sio_in,
   input wire logic sio_out,
   input wire logic sio_oe
);
   logic drv;
   logic hd;
   logic flip;
   initial begin
      serial_shift_clock = 1'b0;
      cs_n = 1'b1;
      drv = 1'b0;
      hd = 1'b0;
      flip = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // released line shows a changing pattern, never the last value
   always @(serial_shift_clock) flip = ~flip;
   assign sio_in = sio_oe ? sio_out : (drv ? hd : flip);
   ////////////////////////////////////////////////////////////////////////////
   // one frame: read 16 bits, then write the low n bits of wr, msb first
   task automatic frame(input logic [15:0] wr, input int n, output logic [15:0] rd, output logic [15:0] oe);
      #7 cs_n = 1'b0;
      #24;
      for (int i = 15; i >= 0; i--) begin
         serial_shift_clock = 1'b1;
         rd[i] = sio_in;
         oe[i] = sio_oe;
         #24 serial_shift_clock = 1'b0;
         #24;
      end
      drv = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         hd = wr[i];
         #24 serial_shift_clock = 1'b1;
         #24 serial_shift_clock = 1'b0;
      end
      drv = 1'b0;
      cs_n = 1'b1;
      #100;
   endtask
endmodule

// [tsr_serial_regs_test.sv]
/*
 * self-checking testbench for tsr_serial_regs: reads words and writes
 * mode commands through the host model and checks pins and mode.
 * assumes tsr_pkg and tsr_host_model are compiled first.
 */
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("Error %0t: got %h want %h", $time, a, b); end end
module tsr_serial_regs_test;
   import tsr_pkg::*;
   logic clk_sys;
   logic rstn;
   logic serial_shift_clock;
   logic cs_n;
   logic sio_in;
   logic sio_out;
   logic sio_oe;
   logic shutdown;
   logic [TEMP_W-1:0] temp_code;
   logic [15:0] rd;
   logic [15:0] oe;
   int miscompares = 0;
   int n_checks = 0;
   logic [TEMP_W-1:0] temps [4] = '{11'h258, 11'h7ff, 11'h000, 11'h400};
   logic [7:0] codes [7] = '{8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f};
   ////////////////////////////////////////////////////////////////////////////
   tsr_serial_regs u_dut (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .serial_shift_clock(serial_shift_clock),
      .cs_n(cs_n),
      .sio_in(sio_in),
      .sio_out(sio_out),
      .sio_oe(sio_oe),
      .temp_code(temp_code),
      .shutdown(shutdown)
   );
   tsr_host_model u_host (
      .serial_shift_clock(serial_shift_clock),
      .cs_n(cs_n),
      .sio_in(sio_in),
      .sio_out(sio_out),
      .sio_oe(sio_oe)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic rd_word(input logic [15:0] want);
      u_host.frame(16'h0000, 0, rd, oe);
      `CHK(rd[15:2], want[15:2])
      `CHK(oe, 16'hfffc)
   endtask
   task automatic wr_cmd(input logic [15:0] w, input int n, input logic want);
      u_host.frame(w, n, rd, oe);
      `CHK(shutdown, want)
   endtask
   task automatic do_reset;
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #300000;
      miscompares++;
      report_and_stop;
   end
   initial begin
      rstn = 1'b0;
      temp_code = 11'h000;
      do_reset;
      `CHK(shutdown, 1'b0)
      foreach (temps[i]) begin
         @(posedge clk_sys);
         temp_code <= temps[i];
         repeat (4) @(posedge clk_sys);
         rd_word({temps[i], 5'h1c});
      end
      wr_cmd(16'h5aff, 16, 1'b1);
      rd_word({ID_CODE, 5'h00});
      wr_cmd(16'h0000, 3, 1'b1);
      wr_cmd(16'h0000, 0, 1'b1);
      wr_cmd(16'hff00, 16, 1'b0);
      rd_word({temps[3], 5'h1c});
      foreach (codes[i]) begin
         wr_cmd(16'h00ff, 8, 1'b1);
         wr_cmd({8'h00, codes[i]}, 8, 1'b0);
      end
      wr_cmd(16'h00ff, 12, 1'b1);
      do_reset;
      `CHK(shutdown, 1'b0)
      rd_word({temps[3], 5'h1c});
      report_and_stop;
   end
endmodule
